/* include/sfio_map.svh */
/*
 * Register offsets, field positions, reset values and timing counts of the
 * servo loop block.
 * Assumes a 100 MHz core clock and word-indexed register addresses.
 */
`ifndef SFIO_MAP_SVH
`define SFIO_MAP_SVH

// ****************************************************
// Register indices
// ****************************************************
`define SFIO_A_CTRL 8'h00
`define SFIO_A_PROPORTIONAL_GAIN 8'h01
`define SFIO_A_DERIVATIVE_GAIN 8'h02
`define SFIO_A_KVELFB 8'h03
`define SFIO_A_INTEGRAL_GAIN 8'h04
`define SFIO_A_IMODE 8'h05
`define SFIO_A_ICLAMP 8'h06
`define SFIO_A_KFF 8'h07
`define SFIO_A_PERIOD 8'h08
`define SFIO_A_IN_TRIG 8'h09
`define SFIO_A_IN_FUNC 8'h0A
`define SFIO_A_OUT_MODE 8'h0B
`define SFIO_A_OUT_VAL 8'h0C
`define SFIO_A_POSITION 8'h0D
`define SFIO_A_DEMAND 8'h0E
`define SFIO_A_IN_STAT 8'h0F

// ****************************************************
// Fields and reset values
// ****************************************************
`define SFIO_CTRL_SERVO_EN 0
`define SFIO_CTRL_DRIVE_EN 1
`define SFIO_FN_W 4
`define SFIO_N_FN 3
`define SFIO_N_IN 8
`define SFIO_N_OUT 4
`define SFIO_GAIN_FRAC 8
`define SFIO_RST_GAIN 16'h0000
`define SFIO_RST_ICLAMP 16'h07FF
`define SFIO_DAC_FULL 13'sh0800
`define SFIO_DAC_MID 14'h0800
`define SFIO_DAC_TOP 12'hFFF

// ****************************************************
// Timing
// ****************************************************
`define SFIO_CLK_NS 10
`define SFIO_US_NS 1000
`define SFIO_US_CYCLES (`SFIO_US_NS / `SFIO_CLK_NS)
`define SFIO_LOOP_DEF_US 1000

`endif

/* include/sfio_pkg.sv */
/*
 * Types of the servo loop block: trigger conditions, integral modes and
 * servo sequencer states.
 * Assumes nothing of its surroundings.
 */
package sfio_pkg;

	// Input trigger condition
	typedef enum logic [2:0] {
		SFIO_TRIG_HIGH = 3'h0,
		SFIO_TRIG_LOW = 3'h1,
		SFIO_TRIG_RISE = 3'h2,
		SFIO_TRIG_FALL = 3'h3,
		SFIO_TRIG_BOTH = 3'h4
	} sfio_trig_t;

	// Integral term application
	typedef enum logic [1:0] {
		SFIO_INT_NEVER = 2'h0,
		SFIO_INT_ALWAYS = 2'h1,
		SFIO_INT_SMART = 2'h2
	} sfio_imode_t;

	// Servo sequencer
	typedef enum logic [2:0] {
		SFIO_S_WAIT = 3'h1,
		SFIO_S_TERMS = 3'h2,
		SFIO_S_SUM = 3'h4
	} sfio_state_t;

endpackage

/* hw/sfio_quad_counter.sv */
/*
 * Quadrature encoder position counter, four counts per encoder line.
 * Assumes channel pins asynchronous to the core clock.
 */
`timescale 1ns/100ps
module sfio_quad_counter (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_b,
	// Encoder pins
	input wire logic i_enc_a,
	input wire logic i_enc_b,
	// Position
	output logic [31:0] o_count
);
	import sfio_pkg::*;

	logic a_s1_reg, a_s2_reg, b_s1_reg, b_s2_reg, a_old_reg, b_old_reg;
	logic [31:0] cnt_reg, cnt_next;
	logic single, inc, dec;

	// Two-stage synchronisers and previous state
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			a_s1_reg <= 1'b0;
			a_s2_reg <= 1'b0;
			b_s1_reg <= 1'b0;
			b_s2_reg <= 1'b0;
			a_old_reg <= 1'b0;
			b_old_reg <= 1'b0;
		end else begin
			a_s1_reg <= i_enc_a;
			a_s2_reg <= a_s1_reg;
			b_s1_reg <= i_enc_b;
			b_s2_reg <= b_s1_reg;
			a_old_reg <= a_s2_reg;
			b_old_reg <= b_s2_reg;
		end
	end

	// An edge on one channel alone steps the count; edges on both at once do not
	always_comb begin
		single = (a_old_reg ^ a_s2_reg) ^ (b_old_reg ^ b_s2_reg);
		inc = single && (a_old_reg ^ b_s2_reg);
		dec = single && (b_old_reg ^ a_s2_reg);
		cnt_next = cnt_reg;
		if (inc)
			cnt_next = cnt_reg + 32'h1;
		else if (dec)
			cnt_next = cnt_reg - 32'h1;
	end

	// Count register
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b)
			cnt_reg <= 32'h0;
		else
			cnt_reg <= cnt_next;
	end

	assign o_count = cnt_reg;

	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rst_b);

	AST_QUAD_STEP: assert property (single |=> o_count != $past(o_count))
		else $error("quadrature edge did not move the count");
endmodule

/* hw/sfio_servo_axis.sv */
/*
 * Servo axis: position loop with feedforward, demand DAC code, digital
 * input triggers and special functions, digital outputs, register port.
 * Assumes profile demands on the core clock and asynchronous pins.
 */
`timescale 1ns/100ps
`include "sfio_map.svh"
module sfio_servo_axis #(
	parameter logic [15:0] P_LOOP_DEF_US = 16'(`SFIO_LOOP_DEF_US)
) (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_b,
	// Register port
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	// Encoder and profile demand
	input wire logic i_enc_a,
	input wire logic i_enc_b,
	input wire logic [31:0] i_profile_pos,
	input wire logic [31:0] i_profile_vel,
	// Digital I/O
	input wire logic [`SFIO_N_IN-1:0] i_din,
	output logic [`SFIO_N_OUT-1:0] o_dout,
	output logic o_home,
	output logic o_fwd_limit,
	output logic o_rev_limit,
	// Demand
	output logic [11:0] o_dac_code,
	output logic o_servo_tick
);
	import sfio_pkg::*;

	// ****************************************************
	// Helpers
	// ****************************************************
	function automatic logic signed [32:0] d33(input logic [31:0] a, input logic [31:0] b);
		d33 = $signed({a[31], a}) - $signed({b[31], b});
	endfunction

	function automatic logic signed [17:0] sat18(input logic signed [32:0] x);
		if (x > 33'sh00001FFFF)
			sat18 = 18'sh1FFFF;
		else if (x < 33'sh1FFFE0000)
			sat18 = 18'sh20000;
		else
			sat18 = x[17:0];
	endfunction

	function automatic logic signed [39:0] mul(input logic signed [15:0] g, input logic signed [17:0] v);
		logic signed [39:0] gx, vx;
		gx = {{24{g[15]}}, g};
		vx = {{22{v[17]}}, v};
		mul = gx * vx;
	endfunction

	// ****************************************************
	// Registers
	// ****************************************************
	logic [1:0] ctrl_reg, ctrl_next;
	logic [15:0] kp_reg, kp_next, kd_reg, kd_next, kv_reg, kv_next, ki_reg, ki_next;
	logic [15:0] kff_reg, kff_next, iclamp_reg, iclamp_next, period_reg, period_next;
	logic [1:0] imode_reg, imode_next;
	logic [3*`SFIO_N_IN-1:0] trig_reg, trig_next;
	logic [`SFIO_N_FN*`SFIO_FN_W-1:0] func_reg, func_next;
	logic [`SFIO_N_OUT-1:0] omode_reg, omode_next, oval_reg, oval_next, dout_reg, dout_next;
	logic [`SFIO_N_IN-1:0] in_hit_reg, in_hit_next, hit_clr, hit;
	logic [`SFIO_N_IN-1:0] din_s1_reg, din_s2_reg, din_s3_reg;
	logic [`SFIO_N_FN-1:0] fn_reg, fn_next;
	logic [31:0] rdata_reg, rdata_next, pos;
	logic [6:0] us_cnt_reg, us_cnt_next;
	logic [15:0] loop_cnt_reg, loop_cnt_next;
	logic us_tick, servo_tick;
	sfio_state_t state_reg, state_next;
	logic [31:0] pos_prev_reg, pos_prev_next;
	logic signed [17:0] err_reg, err_next, der_reg, der_next, velm_reg, velm_next;
	logic signed [17:0] veld_reg, veld_next, integ_reg, integ_next;
	logic vconst_reg, vconst_next;
	logic signed [39:0] sum_reg, sum_next, scaled;
	logic signed [12:0] demand_reg, demand_next;
	logic [11:0] dac_reg, dac_next;
	logic signed [19:0] isum, ilim;
	logic signed [13:0] dac_sum;
	logic servo_en, iapply;

	sfio_quad_counter u_quad (
		.i_mclk(i_mclk),
		.i_rst_b(i_rst_b),
		.i_enc_a(i_enc_a),
		.i_enc_b(i_enc_b),
		.o_count(pos)
	);

	// Register writes, sticky trigger flags and read data
	always_comb begin
		ctrl_next = ctrl_reg;
		kp_next = kp_reg;
		kd_next = kd_reg;
		kv_next = kv_reg;
		ki_next = ki_reg;
		imode_next = imode_reg;
		iclamp_next = iclamp_reg;
		kff_next = kff_reg;
		period_next = period_reg;
		trig_next = trig_reg;
		func_next = func_reg;
		omode_next = omode_reg;
		oval_next = oval_reg;
		hit_clr = '0;
		if (i_wr) begin
			case (i_addr)
				`SFIO_A_CTRL: ctrl_next = i_wdata[1:0];
				`SFIO_A_PROPORTIONAL_GAIN: kp_next = i_wdata[15:0];
				`SFIO_A_DERIVATIVE_GAIN: kd_next = i_wdata[15:0];
				`SFIO_A_KVELFB: kv_next = i_wdata[15:0];
				`SFIO_A_INTEGRAL_GAIN: ki_next = i_wdata[15:0];
				`SFIO_A_IMODE: imode_next = i_wdata[1:0];
				`SFIO_A_ICLAMP: iclamp_next = i_wdata[15:0];
				`SFIO_A_KFF: kff_next = i_wdata[15:0];
				`SFIO_A_PERIOD: period_next = i_wdata[15:0];
				`SFIO_A_IN_TRIG: trig_next = i_wdata[3*`SFIO_N_IN-1:0];
				`SFIO_A_IN_FUNC: func_next = i_wdata[`SFIO_N_FN*`SFIO_FN_W-1:0];
				`SFIO_A_OUT_MODE: omode_next = i_wdata[`SFIO_N_OUT-1:0];
				`SFIO_A_OUT_VAL: oval_next = i_wdata[`SFIO_N_OUT-1:0];
				`SFIO_A_IN_STAT: hit_clr = i_wdata[`SFIO_N_IN-1:0];
				default: ;
			endcase
		end
		in_hit_next = (in_hit_reg & ~hit_clr) | hit; // Set wins over clear
		rdata_next = 32'h0;
		if (i_rd) begin
			case (i_addr)
				`SFIO_A_CTRL: rdata_next = {30'h0, ctrl_reg};
				`SFIO_A_PROPORTIONAL_GAIN: rdata_next = {16'h0, kp_reg};
				`SFIO_A_DERIVATIVE_GAIN: rdata_next = {16'h0, kd_reg};
				`SFIO_A_KVELFB: rdata_next = {16'h0, kv_reg};
				`SFIO_A_INTEGRAL_GAIN: rdata_next = {16'h0, ki_reg};
				`SFIO_A_IMODE: rdata_next = {30'h0, imode_reg};
				`SFIO_A_ICLAMP: rdata_next = {16'h0, iclamp_reg};
				`SFIO_A_KFF: rdata_next = {16'h0, kff_reg};
				`SFIO_A_PERIOD: rdata_next = {16'h0, period_reg};
				`SFIO_A_IN_TRIG: rdata_next = {8'h0, trig_reg};
				`SFIO_A_IN_FUNC: rdata_next = {20'h0, func_reg};
				`SFIO_A_OUT_MODE: rdata_next = {28'h0, omode_reg};
				`SFIO_A_OUT_VAL: rdata_next = {28'h0, oval_reg};
				`SFIO_A_POSITION: rdata_next = pos;
				`SFIO_A_DEMAND: rdata_next = {{19{demand_reg[12]}}, demand_reg};
				`SFIO_A_IN_STAT: rdata_next = {16'h0, din_s2_reg, in_hit_reg};
				default: rdata_next = 32'h0;
			endcase
		end
	end

	// Register file storage
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			ctrl_reg <= 2'h0;
			kp_reg <= `SFIO_RST_GAIN;
			kd_reg <= `SFIO_RST_GAIN;
			kv_reg <= `SFIO_RST_GAIN;
			ki_reg <= `SFIO_RST_GAIN;
			imode_reg <= SFIO_INT_ALWAYS;
			iclamp_reg <= `SFIO_RST_ICLAMP;
			kff_reg <= `SFIO_RST_GAIN;
			period_reg <= P_LOOP_DEF_US;
			trig_reg <= '0;
			func_reg <= '0;
			omode_reg <= '0;
			oval_reg <= '0;
			in_hit_reg <= '0;
			rdata_reg <= 32'h0;
		end else begin
			ctrl_reg <= ctrl_next;
			kp_reg <= kp_next;
			kd_reg <= kd_next;
			kv_reg <= kv_next;
			ki_reg <= ki_next;
			imode_reg <= imode_next;
			iclamp_reg <= iclamp_next;
			kff_reg <= kff_next;
			period_reg <= period_next;
			trig_reg <= trig_next;
			func_reg <= func_next;
			omode_reg <= omode_next;
			oval_reg <= oval_next;
			in_hit_reg <= in_hit_next;
			rdata_reg <= rdata_next;
		end
	end

	// ****************************************************
	// Digital inputs and outputs
	// ****************************************************
	// Input synchronisers plus one stage for edges
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			din_s1_reg <= '0;
			din_s2_reg <= '0;
			din_s3_reg <= '0;
		end else begin
			din_s1_reg <= i_din;
			din_s2_reg <= din_s1_reg;
			din_s3_reg <= din_s2_reg;
		end
	end

	// Per-input trigger condition
	genvar gi;
	for (gi = 0; gi < `SFIO_N_IN; gi++) begin : g_in
		always_comb begin
			case (trig_reg[3*gi +: 3])
				SFIO_TRIG_HIGH: hit[gi] = din_s2_reg[gi];
				SFIO_TRIG_LOW: hit[gi] = !din_s2_reg[gi];
				SFIO_TRIG_RISE: hit[gi] = din_s2_reg[gi] && !din_s3_reg[gi];
				SFIO_TRIG_FALL: hit[gi] = !din_s2_reg[gi] && din_s3_reg[gi];
				SFIO_TRIG_BOTH: hit[gi] = din_s2_reg[gi] ^ din_s3_reg[gi];
				default: hit[gi] = 1'b0;
			endcase
		end
		// Rising trigger gives one pulse per edge on every input
		AST_TRIG_RISE: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
			trig_reg[3*gi +: 3] == SFIO_TRIG_RISE && $rose(din_s2_reg[gi])
			|-> hit[gi] ##1 !hit[gi] || $rose(din_s2_reg[gi]))
			else $error("rising trigger not a single pulse");
	end

	// Special functions and output sources
	always_comb begin
		for (int k = 0; k < `SFIO_N_FN; k++)
			fn_next[k] = func_reg[`SFIO_FN_W*k+3] && hit[func_reg[`SFIO_FN_W*k +: 3]];
		for (int j = 0; j < `SFIO_N_OUT; j++)
			dout_next[j] = omode_reg[j] ? ctrl_reg[`SFIO_CTRL_DRIVE_EN] : oval_reg[j];
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			fn_reg <= '0;
			dout_reg <= '0;
		end else begin
			fn_reg <= fn_next;
			dout_reg <= dout_next;
		end
	end

	// ****************************************************
	// Servo period and loop
	// ****************************************************
	// Microsecond divider and loop period counter
	always_comb begin
		us_tick = (us_cnt_reg == 7'(`SFIO_US_CYCLES - 1));
		us_cnt_next = us_tick ? 7'h0 : us_cnt_reg + 7'h1;
		servo_tick = us_tick && (({1'b0, loop_cnt_reg} + 17'h1) >= {1'b0, period_reg});
		loop_cnt_next = loop_cnt_reg;
		if (servo_tick)
			loop_cnt_next = 16'h0;
		else if (us_tick)
			loop_cnt_next = loop_cnt_reg + 16'h1;
	end

	// Servo sequencer: sample, form terms, saturate
	always_comb begin
		servo_en = ctrl_reg[`SFIO_CTRL_SERVO_EN];
		state_next = state_reg;
		pos_prev_next = pos_prev_reg;
		err_next = err_reg;
		der_next = der_reg;
		velm_next = velm_reg;
		veld_next = veld_reg;
		vconst_next = vconst_reg;
		integ_next = integ_reg;
		sum_next = sum_reg;
		demand_next = demand_reg;
		dac_next = dac_reg;
		iapply = 1'b0;
		isum = 20'(integ_reg) + 20'(err_reg);
		ilim = 20'($signed({4'h0, iclamp_reg}));
		scaled = sum_reg >>> `SFIO_GAIN_FRAC;
		dac_sum = 14'h0;
		case (state_reg)
			SFIO_S_WAIT: begin
				if (servo_tick) begin
					err_next = sat18(d33(i_profile_pos, pos));
					der_next = sat18(33'(err_next) - 33'(err_reg));
					velm_next = sat18(d33(pos, pos_prev_reg));
					pos_prev_next = pos;
					veld_next = sat18(33'($signed(i_profile_vel)));
					vconst_next = (sat18(33'($signed(i_profile_vel))) == veld_reg);
					state_next = SFIO_S_TERMS;
				end
			end
			SFIO_S_TERMS: begin
				iapply = servo_en && (imode_reg == SFIO_INT_ALWAYS ||
					(imode_reg == SFIO_INT_SMART && vconst_reg));
				if (!servo_en || imode_reg == SFIO_INT_NEVER)
					integ_next = 18'sh0;
				else if (iapply)
					integ_next = (isum > ilim) ? ilim[17:0] : (isum < -ilim) ? 18'(-ilim) : isum[17:0];
				// Feedforward adds into the same sum as the feedback terms; zero gains vanish
				sum_next = mul(kp_reg, err_reg) + mul(kd_reg, der_reg) - mul(kv_reg, velm_reg)
					+ (iapply ? mul(ki_reg, integ_next) : 40'sh0)
					+ mul(kff_reg, veld_reg);
				state_next = SFIO_S_SUM;
			end
			SFIO_S_SUM: begin
				if (!servo_en)
					demand_next = 13'sh0;
				else if (scaled > `SFIO_DAC_FULL)
					demand_next = `SFIO_DAC_FULL;
				else if (scaled < -`SFIO_DAC_FULL)
					demand_next = -`SFIO_DAC_FULL;
				else
					demand_next = scaled[12:0];
				dac_sum = 14'(demand_next) + `SFIO_DAC_MID;
				dac_next = dac_sum[12] ? `SFIO_DAC_TOP : dac_sum[11:0];
				state_next = SFIO_S_WAIT;
			end
			default: state_next = SFIO_S_WAIT;
		endcase
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			us_cnt_reg <= 7'h0;
			loop_cnt_reg <= 16'h0;
			state_reg <= SFIO_S_WAIT;
			pos_prev_reg <= 32'h0;
			err_reg <= 18'sh0;
			der_reg <= 18'sh0;
			velm_reg <= 18'sh0;
			veld_reg <= 18'sh0;
			vconst_reg <= 1'b0;
			integ_reg <= 18'sh0;
			sum_reg <= 40'sh0;
			demand_reg <= 13'sh0;
			dac_reg <= 12'h800;
		end else begin
			us_cnt_reg <= us_cnt_next;
			loop_cnt_reg <= loop_cnt_next;
			state_reg <= state_next;
			pos_prev_reg <= pos_prev_next;
			err_reg <= err_next;
			der_reg <= der_next;
			velm_reg <= velm_next;
			veld_reg <= veld_next;
			vconst_reg <= vconst_next;
			integ_reg <= integ_next;
			sum_reg <= sum_next;
			demand_reg <= demand_next;
			dac_reg <= dac_next;
		end
	end

	// Output drive
	assign o_rdata = rdata_reg;
	assign o_dout = dout_reg;
	assign o_home = fn_reg[0];
	assign o_fwd_limit = fn_reg[1];
	assign o_rev_limit = fn_reg[2];
	assign o_dac_code = dac_reg;
	assign o_servo_tick = servo_tick;

	// ****************************************************
	// Checks
	// ****************************************************
	logic [23:0] gap_reg;
	logic seen_reg, stable_reg;
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			gap_reg <= 24'h0;
			seen_reg <= 1'b0;
			stable_reg <= 1'b0;
		end else begin
			gap_reg <= servo_tick ? 24'h0 : gap_reg + 24'h1;
			seen_reg <= seen_reg || servo_tick;
			stable_reg <= (i_wr && i_addr == `SFIO_A_PERIOD) ? 1'b0 : (stable_reg || servo_tick);
		end
	end

	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rst_b);

	sequence seq_terms; state_reg == SFIO_S_TERMS; endsequence
	sequence seq_sum; state_reg == SFIO_S_SUM ##1 state_reg == SFIO_S_WAIT; endsequence

	AST_LOOP_SEQ: assert property (servo_tick && state_reg == SFIO_S_WAIT |=> seq_terms ##1 seq_sum)
		else $error("servo cycle did not run its three steps");
	AST_LOOP_PERIOD: assert property (servo_tick && seen_reg && stable_reg && period_reg != 16'h0
		|-> gap_reg == 24'(period_reg) * 24'(`SFIO_US_CYCLES) - 24'h1)
		else $error("servo period differs from programmed value");
	AST_DAC_TOP: assert property (state_reg == SFIO_S_SUM && servo_en && scaled >= `SFIO_DAC_FULL
		|=> o_dac_code == `SFIO_DAC_TOP)
		else $error("positive demand did not saturate");
	AST_DAC_BOTTOM: assert property (state_reg == SFIO_S_SUM && servo_en && scaled <= -`SFIO_DAC_FULL
		|=> o_dac_code == 12'h000)
		else $error("negative demand did not saturate");
	AST_DAC_MAP: assert property (state_reg == SFIO_S_SUM |=> o_dac_code == 12'(14'(demand_reg) + `SFIO_DAC_MID)
		|| (demand_reg == `SFIO_DAC_FULL && o_dac_code == `SFIO_DAC_TOP))
		else $error("DAC code does not follow demand");
	AST_FF_ONLY: assert property (state_reg == SFIO_S_TERMS && kp_reg == 16'h0 && kd_reg == 16'h0
		&& kv_reg == 16'h0 && !iapply |=> sum_reg == mul($past(kff_reg), veld_reg))
		else $error("feedforward product missing from sum");
	AST_FWD_FN: assert property (func_reg[7] && hit[func_reg[6:4]] |=> o_fwd_limit)
		else $error("forward limit did not follow its input");
	AST_DRIVE_EN: assert property (omode_reg[0] |=> o_dout[0] == $past(ctrl_reg[`SFIO_CTRL_DRIVE_EN]))
		else $error("drive enable output wrong");
	AST_INT_NEVER: assert property (state_reg == SFIO_S_TERMS && imode_reg == SFIO_INT_NEVER
		|=> integ_reg == 18'sh0)
		else $error("integral kept in never mode");
endmodule

/* verification/sfio_drive_model.sv */
/*
 * Drive, motor and encoder partner: turns whole encoder lines into
 * quadrature edges on two channels.
 * Assumes the bench calls move and that the clock runs meanwhile.
 */
`timescale 1ns/100ps
module sfio_drive_model (
	// Clock
	input wire logic i_mclk,
	// Encoder channels
	output logic o_enc_a,
	output logic o_enc_b
);
	logic [1:0] phase_reg = 2'h0;
	// Gray phase to channels, B leads A when the counter should count up
	assign o_enc_a = phase_reg[1];
	assign o_enc_b = phase_reg[1] ^ phase_reg[0];
	// One quadrature edge every six cycles, four edges a line
	task automatic move(input int lines, input logic fwd);
		repeat (4 * lines) begin
			repeat (6) @(posedge i_mclk);
			phase_reg <= fwd ? phase_reg + 2'h1 : phase_reg - 2'h1;
		end
	endtask
endmodule

/* verification/tb_top.sv */
/*
 * Self-checking bench of the servo axis: register port, encoder count,
 * demand code, integral modes, input triggers, outputs, loop period.
 * Assumes the drive model on the encoder pins and a short loop period.
 */
`timescale 1ns/100ps
`include "sfio_map.svh"
module tb_top;
	import sfio_pkg::*;
	localparam int LP = 5;
	logic i_mclk = 1'b0;
	logic i_rst_b = 1'b0;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [7:0] i_addr = 8'h00;
	logic [7:0] i_din = 8'h00;
	logic [31:0] i_wdata = 32'h0, i_profile_pos = 32'h0, i_profile_vel = 32'h0, o_rdata, rd;
	logic [3:0] o_dout;
	logic [11:0] o_dac_code;
	logic enc_a, enc_b, o_home, o_fwd_limit, o_rev_limit, o_servo_tick;
	int n_mismatch = 0, samples_checked = 0, cyc = 0, last = 0, gap = 0, n_home = 0, n_fwd = 0, n_rev = 0;
	logic [7:0] ra [8] = '{`SFIO_A_CTRL, `SFIO_A_PROPORTIONAL_GAIN, `SFIO_A_IMODE, `SFIO_A_ICLAMP, `SFIO_A_PERIOD,
		`SFIO_A_POSITION, `SFIO_A_DEMAND, 8'h10};
	logic [31:0] rv [8] = '{32'h0, 32'h0, 32'h1, 32'h7FF, 32'(LP), 32'h0, 32'h0, 32'h0};
	int trig_exp [5] = '{20, 20, 1, 1, 2};
	int imode_exp [3] = '{32'h800, 32'h814, 32'h814};

	always #5 i_mclk = ~i_mclk;

	sfio_drive_model i_drive (.i_mclk(i_mclk), .o_enc_a(enc_a), .o_enc_b(enc_b));

	sfio_servo_axis #(.P_LOOP_DEF_US(16'(LP))) i_dut (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_enc_a(enc_a), .i_enc_b(enc_b),
		.i_profile_pos(i_profile_pos), .i_profile_vel(i_profile_vel), .i_din(i_din), .o_dout(o_dout),
		.o_home(o_home), .o_fwd_limit(o_fwd_limit), .o_rev_limit(o_rev_limit), .o_dac_code(o_dac_code),
		.o_servo_tick(o_servo_tick));

	// Tick spacing and special function activity
	always @(posedge i_mclk) begin
		cyc++;
		if (o_servo_tick === 1'b1) begin
			gap = cyc - last;
			last = cyc;
		end
		if (o_home === 1'b1) n_home++;
		if (o_fwd_limit === 1'b1) n_fwd++;
		if (o_rev_limit === 1'b1) n_rev++;
	end

	// ****************************************************
	// Access and compare tasks
	// ****************************************************
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_mclk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_mclk);
		i_wr <= 1'b0;
	endtask
	task automatic rdr(input logic [7:0] a, output logic [31:0] d);
		@(posedge i_mclk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_mclk);
		i_rd <= 1'b0;
		@(negedge i_mclk);
		d = o_rdata;
		@(posedge i_mclk);
	endtask
	task automatic per(input int n);
		repeat (n * LP * 100 + 10) @(posedge i_mclk);
	endtask
	// Align to a tick, move one line forward, check the demand of the next period
	task automatic ffstep(input string nm, input logic [11:0] exp);
		do begin
			@(posedge i_mclk);
		end while (o_servo_tick !== 1'b1);
		i_drive.move(1, 1'b1);
		repeat (LP * 100) @(posedge i_mclk);
		chk(nm, {20'h0, o_dac_code}, {20'h0, exp});
	endtask
	task automatic tally_and_finish;
		$display("compares %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// Hang guard
	initial begin
		repeat (60000) @(posedge i_mclk);
		n_mismatch++;
		tally_and_finish;
	end

	// ****************************************************
	// Tests
	// ****************************************************
	initial begin
		repeat (3) @(posedge i_mclk);
		i_rst_b <= 1'b1;
		wr(`SFIO_A_POSITION, 32'h55);
		wr(8'h10, 32'h55);
		for (int k = 0; k < 8; k++) begin
			rdr(ra[k], rd);
			chk("reset reg", rd, rv[k]);
		end
		chk("idle dac", {20'h0, o_dac_code}, 32'h800);
		$display("test reset done");
		i_drive.move(3, 1'b1);
		repeat (8) @(posedge i_mclk);
		rdr(`SFIO_A_POSITION, rd);
		chk("pos up", rd, 32'd12);
		i_drive.move(1, 1'b0);
		repeat (8) @(posedge i_mclk);
		rdr(`SFIO_A_POSITION, rd);
		chk("pos down", rd, 32'd8);
		$display("test encoder done");
		i_profile_pos <= 32'd8;
		i_profile_vel <= 32'd100;
		wr(`SFIO_A_KFF, 32'h100);
		wr(`SFIO_A_CTRL, 32'h1);
		per(3);
		chk("ff dac", {20'h0, o_dac_code}, 32'h864);
		rdr(`SFIO_A_DEMAND, rd);
		chk("ff demand", rd, 32'd100);
		chk("tick gap", 32'(gap), 32'(LP * 100));
		// The velocity and derivative feedback terms show only once their gains are set
		ffstep("zero gain", 12'h864);
		wr(`SFIO_A_KVELFB, 32'h100);
		ffstep("vel fb gain", 12'h860);
		wr(`SFIO_A_DERIVATIVE_GAIN, 32'h100);
		ffstep("deriv gain", 12'h85C);
		i_profile_vel <= 32'd5000;
		per(3);
		chk("sat top", {20'h0, o_dac_code}, 32'hFFF);
		i_profile_vel <= -32'sd5000;
		per(3);
		chk("sat bottom", {20'h0, o_dac_code}, 32'h000);
		$display("test demand done");
		i_profile_vel <= 32'd0;
		i_profile_pos <= 32'd30;
		wr(`SFIO_A_KFF, 32'h0);
		wr(`SFIO_A_INTEGRAL_GAIN, 32'h100);
		wr(`SFIO_A_ICLAMP, 32'd20);
		for (int m = 0; m < 3; m++) begin
			wr(`SFIO_A_CTRL, 32'h0);
			wr(`SFIO_A_IMODE, 32'(m));
			wr(`SFIO_A_CTRL, 32'h1);
			per(5);
			chk("integral", {20'h0, o_dac_code}, imode_exp[m]);
		end
		$display("test integral done");
		wr(`SFIO_A_IN_FUNC, 32'hBBB);
		for (int m = 0; m < 5; m++) begin
			wr(`SFIO_A_IN_TRIG, 32'(m) << 9);
			repeat (8) @(posedge i_mclk);
			#1 n_home = 0;
			n_fwd = 0;
			n_rev = 0;
			repeat (10) @(posedge i_mclk);
			i_din <= 8'h08;
			repeat (20) @(posedge i_mclk);
			i_din <= 8'h00;
			repeat (10) @(posedge i_mclk);
			#1 chk("home", 32'(n_home), 32'(trig_exp[m]));
			chk("fwd limit", 32'(n_fwd), 32'(trig_exp[m]));
			chk("rev limit", 32'(n_rev), 32'(trig_exp[m]));
		end
		$display("test inputs done");
		wr(`SFIO_A_OUT_VAL, 32'h6);
		wr(`SFIO_A_OUT_MODE, 32'h1);
		wr(`SFIO_A_CTRL, 32'h3);
		repeat (3) @(posedge i_mclk);
		chk("dout enable", {28'h0, o_dout}, 32'h7);
		wr(`SFIO_A_CTRL, 32'h1);
		repeat (3) @(posedge i_mclk);
		chk("dout general", {28'h0, o_dout}, 32'h6);
		$display("test outputs done");
		wr(`SFIO_A_PERIOD, 32'd3);
		per(3);
		chk("period", 32'(gap), 32'd300);
		$display("test period done");
		tally_and_finish;
	end
endmodule
